// ==== logic/fpr_consts.svh ====
// constants for the fault protection and reporting block
// assumes one 100 MHz system clock; no bus, all controls are ports
`ifndef FPR_CONSTS_SVH
`define FPR_CONSTS_SVH
`define FPR_CFG_BRIDGE 2'h0
`define FPR_CFG_PARALLEL 2'h2
`define FPR_CFG_SINGLE 2'h3
`define FPR_NUM_HB 4
`define FPR_SYNC_STAGES 3
`define FPR_HB_AB 4'h3
`define FPR_HB_CD 4'hc
`define FPR_HB_ALL 4'hf
`endif

// ==== logic/fpr_pkg.sv ====
// types for the fault protection and reporting block
// assumes fpr_consts.svh is available on the include path
`default_nettype none
package fpr_pkg;
	typedef enum logic [1:0] {
		fpr_cfg_bridge_t_v = 2'h0,
		fpr_cfg_unused_v = 2'h1,
		fpr_cfg_parallel_v = 2'h2,
		fpr_cfg_single_v = 2'h3
	} fpr_cfg_t;
	typedef enum logic [1:0] {
		fpr_st_normal = 2'b00,
		fpr_st_latched = 2'b01,
		fpr_st_auto = 2'b10
	} fpr_state_t;
endpackage
`default_nettype wire

// ==== logic/fpr_sync_if.sv ====
// carries synchronised fault flags from the synchroniser to the top
// assumes both ends run on the same system clock
`timescale 1ns/1ns
`default_nettype none
interface fpr_sync_if;
	logic [3:0] overload;
	logic [3:0] boot_uv;
	logic thermal_err;
	logic thermal_warn;
	logic under_volt;
	modport src (output overload, boot_uv, thermal_err, thermal_warn,
		under_volt);
	modport dst (input overload, boot_uv, thermal_err, thermal_warn,
		under_volt);
endinterface
`default_nettype wire

// ==== logic/fpr_sync.sv ====
// three-flop synchroniser for the asynchronous detector flags
// assumes detector levels are stable for several clock periods
`timescale 1ns/1ns
`default_nettype none
module fpr_sync (
	input wire logic clk_sys_in, // system clock
	input wire logic rst_n_in, // async reset, active low
	input wire logic [11:0] raw_in, // raw detector flags
	fpr_sync_if.src sync_out // filtered flags
);
	logic [11:0] s1;
	logic [11:0] s2;
	logic [11:0] s3;
	logic [11:0] held;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1 <= 12'h000;
			s2 <= 12'h000;
			s3 <= 12'h000;
		end else begin
			s1 <= raw_in;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// a change counts only once stages two and three agree
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			held <= 12'h000;
		end else begin
			for (int i = 0; i < 12; i++) begin
				if (s2[i] == s3[i]) begin
					held[i] <= s3[i];
				end
			end
		end
	end

	assign sync_out.overload = held[3:0];
	assign sync_out.boot_uv = held[7:4];
	assign sync_out.thermal_err = held[8];
	assign sync_out.thermal_warn = held[9];
	assign sync_out.under_volt = held[10];
endmodule
`default_nettype wire

// ==== logic/fpr_scope.sv ====
// maps per-half-bridge faults to the set of half-bridges shut down
// assumes configuration is static while switching
`timescale 1ns/1ns
`default_nettype none
`include "fpr_consts.svh"
module fpr_scope (
	input wire logic [1:0] cfg_in, // output configuration
	input wire logic [3:0] err_in, // local error per half-bridge
	output logic [3:0] off_out // half-bridges to force off
);
	always_comb begin
		off_out = 4'h0;
		if (cfg_in == `FPR_CFG_PARALLEL) begin
			if (|err_in) begin
				off_out = `FPR_HB_ALL;
			end
		end else begin
			if (|err_in[1:0]) begin
				off_out = off_out | `FPR_HB_AB;
			end
			if (|err_in[3:2]) begin
				off_out = off_out | `FPR_HB_CD;
			end
		end
	end
endmodule
`default_nettype wire

// ==== logic/fpr_top.sv ====
// fault protection and error reporting for a four half-bridge stage
// assumes detector flags are asynchronous levels, active high
`timescale 1ns/1ns
`default_nettype none
`include "fpr_consts.svh"
module fpr_top (
	input wire logic clk_sys_in, // system clock 100 MHz
	input wire logic rst_n_in, // reset, also clears latches
	input wire logic [1:0] output_config_in, // configuration select
	input wire logic [3:0] overload_protection_in, // overload per hb
	input wire logic [3:0] boot_uv_in, // bootstrap undervoltage per hb
	input wire logic thermal_shutdown_error_in, // above error temp
	input wire logic thermal_warn_in, // above warning temp
	input wire logic clip_in, // clipping detected
	input wire logic undervoltage_protection_in, // supply low
	output logic [3:0] hb_hiz_out, // 1 forces half-bridge to hi-z
	output logic fault_n_out, // shutdown fault indicator, low active
	output logic clip_thermal_warn_n_out, // clip/warning, low active
	output logic fault_oe_n_out, // open-drain enable, low drives
	output logic warn_oe_n_out // open-drain enable, low drives
);
	fpr_sync_if sy ();
	logic [3:0] ol_latched;
	logic te_latched;
	logic [3:0] scope_err;
	logic [3:0] scope_off;
	logic [3:0] next_hiz;
	logic next_fault;
	logic next_warn;
	logic clip_s1;
	logic clip_s2;
	logic clip_s3;
	logic clip_sync;
	logic [1:0] cfg_s1;
	logic [1:0] cfg_s2;
	logic [1:0] cfg_s3;
	logic [1:0] cfg_sync;
	fpr_pkg::fpr_state_t state;
	fpr_pkg::fpr_state_t next_state;

	fpr_sync u_sync (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.raw_in({1'b0, undervoltage_protection_in, thermal_warn_in,
			thermal_shutdown_error_in, boot_uv_in,
			overload_protection_in}),
		.sync_out(sy)
	);

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clip_s1 <= 1'b0;
			clip_s2 <= 1'b0;
			clip_s3 <= 1'b0;
			clip_sync <= 1'b0;
		end else begin
			clip_s1 <= clip_in;
			clip_s2 <= clip_s1;
			clip_s3 <= clip_s2;
			if (clip_s2 == clip_s3) begin
				clip_sync <= clip_s3;
			end
		end
	end

	// sync config pin; a strap may move at any time
	// same filter as the fault flags so scope and faults line up in time
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_s1 <= `FPR_CFG_BRIDGE;
			cfg_s2 <= `FPR_CFG_BRIDGE;
			cfg_s3 <= `FPR_CFG_BRIDGE;
			cfg_sync <= `FPR_CFG_BRIDGE;
		end else begin
			cfg_s1 <= output_config_in;
			cfg_s2 <= cfg_s1;
			cfg_s3 <= cfg_s2;
			if (cfg_s2 == cfg_s3) begin
				cfg_sync <= cfg_s3;
			end
		end
	end

	// overload never self-clears; only reset releases it
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ol_latched <= 4'h0;
		end else begin
			ol_latched <= ol_latched | sy.overload;
		end
	end

	// thermal error latch
	// only the reset pin clears it; a cooled die stays off on purpose
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			te_latched <= 1'b0;
		end else if (sy.thermal_err) begin
			te_latched <= 1'b1;
		end
	end

	// config selects scope; unused code 01 treated as bridge
	// bootstrap undervoltage kept out of the scope map
	// live overload joins the latch so the first cycle is not lost
	assign scope_err = ol_latched | sy.overload;

	fpr_scope u_scope (
		.cfg_in(cfg_sync),
		.err_in(scope_err),
		.off_out(scope_off)
	);

	// undervoltage clears as soon as the supply recovers
	// undervoltage acts on all four half-bridges and never latches
	always_comb begin
		next_hiz = scope_off;
		if (te_latched || sy.thermal_err || sy.under_volt) begin
			next_hiz = `FPR_HB_ALL;
		end
		next_hiz = next_hiz | sy.boot_uv;
	end

	// bootstrap alone never drives the indicator
	always_comb begin
		next_fault = 1'b1;
		if ((|scope_err) || te_latched || sy.thermal_err ||
			sy.under_volt) begin
			next_fault = 1'b0;
		end
	end

	// warning independent of fault
	// clipping shares the pin, self clearing
	always_comb begin
		next_warn = ~(sy.thermal_warn | clip_sync);
	end

	// recovery mode tracker; latched is left only through reset
	always_comb begin
		case (state)
			fpr_pkg::fpr_st_normal: begin
				if (|ol_latched || te_latched) begin
					next_state = fpr_pkg::fpr_st_latched;
				end else if (!next_fault) begin
					next_state = fpr_pkg::fpr_st_auto;
				end else begin
					next_state = fpr_pkg::fpr_st_normal;
				end
			end
			fpr_pkg::fpr_st_auto: begin
				if (|ol_latched || te_latched) begin
					next_state = fpr_pkg::fpr_st_latched;
				end else if (next_fault) begin
					next_state = fpr_pkg::fpr_st_normal;
				end else begin
					next_state = fpr_pkg::fpr_st_auto;
				end
			end
			fpr_pkg::fpr_st_latched: begin
				next_state = fpr_pkg::fpr_st_latched;
			end
			default: begin
				next_state = fpr_pkg::fpr_st_normal;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= fpr_pkg::fpr_st_normal;
		end else begin
			state <= next_state;
		end
	end

	// open-drain pair, enable low while pulling low
	// pair encoding
	// enables mirror the levels so a released pin floats to its pull-up
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hb_hiz_out <= `FPR_HB_ALL;
			fault_n_out <= 1'b1;
			fault_oe_n_out <= 1'b1;
			clip_thermal_warn_n_out <= 1'b1;
			warn_oe_n_out <= 1'b1;
		end else begin
			hb_hiz_out <= next_hiz;
			fault_n_out <= next_fault;
			fault_oe_n_out <= next_fault;
			clip_thermal_warn_n_out <= next_warn;
			warn_oe_n_out <= next_warn;
		end
	end

	// properties sample one edge after the synchronised flags they watch
	// fault must follow an undervoltage or thermal error shutdown one cycle later
	fault_follow_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_n_in)
		(sy.under_volt || sy.thermal_err) |=> !fault_n_out)
		else $error("fault indicator not low on shutdown");

	te_latch_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_n_in)
		te_latched |=> te_latched && !fault_n_out && hb_hiz_out == 4'hf)
		else $error("thermal latch lost before reset");

	ol_hold_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_n_in)
		(ol_latched[0] && cfg_sync != 2'h2) |=>
		hb_hiz_out[1:0] == 2'h3)
		else $error("overload output released");

	par_all_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_n_in)
		(cfg_sync == 2'h2 && $stable(cfg_sync) &&
		(|scope_err)) |=> hb_hiz_out == 4'hf)
		else $error("parallel scope not all four");

	warn_pin_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_n_in)
		sy.thermal_warn |=> !clip_thermal_warn_n_out)
		else $error("warning indicator not low");

	boot_only_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_n_in)
		(sy.boot_uv[2] && !sy.under_volt && !sy.thermal_err &&
		!te_latched && scope_err == 4'h0) |=>
		fault_n_out && hb_hiz_out == (4'h4 | (4'hb & $past(sy.boot_uv))))
		else $error("bootstrap undervoltage spread");

	uv_recover_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_n_in)
		(!sy.under_volt && !sy.thermal_err && !te_latched &&
		scope_err == 4'h0) |=> fault_n_out)
		else $error("no automatic recovery");

	oe_match_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_n_in)
		fault_oe_n_out == fault_n_out &&
		warn_oe_n_out == clip_thermal_warn_n_out)
		else $error("open-drain enable mismatch");

	latched_state_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_n_in)
		state == fpr_pkg::fpr_st_latched |-> !fault_n_out)
		else $error("latched state but fault high");

	// reset must release the fault pin even while a fault stands
	reset_fault_a: assert property (@(posedge clk_sys_in)
		!rst_n_in |=> fault_n_out)
		else $error("fault indicator low during reset");

	warn_clear_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_n_in)
		(!sy.thermal_warn && !clip_sync) |=> clip_thermal_warn_n_out)
		else $error("warning indicator low without cause");

	uv_all_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_n_in)
		sy.under_volt |=> hb_hiz_out == 4'hf)
		else $error("undervoltage left a half-bridge on");

	cd_pair_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_n_in)
		(ol_latched[2] && cfg_sync != 2'h2) |=>
		hb_hiz_out[3:2] == 2'h3)
		else $error("overload on C did not stop C and D");

	ol_keep_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_n_in)
		(|ol_latched) |=>
		(ol_latched & $past(ol_latched)) == $past(ol_latched))
		else $error("overload latch cleared without reset");

	// a flag may only rise after two agreeing raw samples
	sync_delay_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_n_in)
		$rose(sy.under_volt) |->
		$past(undervoltage_protection_in, 3) &&
		$past(undervoltage_protection_in, 4))
		else $error("undervoltage flag rose too early");
endmodule
`default_nettype wire

// ==== testbench/fpr_ctl_model.sv ====
// system controller model: drives the block's reset, watches the warning pin
// assumes the bench resolves the open-drain pins before they arrive here
`timescale 1ns/1ns
`default_nettype none
module fpr_ctl_model (
	input wire logic clk_sys_in, // system clock
	input wire logic rst_req_in, // bench asks for a reset cycle
	input wire logic fault_pin_in, // resolved fault wire
	input wire logic warn_pin_in, // resolved warning wire
	output logic rst_n_out, // reset to the block, active low
	output logic vol_down_out // volume cut while warned
);
	// reset follows request
	// the request only moves at falling edges, so reset never races
	assign rst_n_out = !rst_req_in;
	always_ff @(posedge clk_sys_in) begin
		vol_down_out <= !warn_pin_in;
	end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// bench for the fault protection block: scenarios with expected values
// assumes fpr_top ports and the controller model beside it
`timescale 1ns/1ns
`default_nettype none
`include "fpr_consts.svh"
module tb_top;
	logic clk_sys_in;
	logic rst_req;
	logic rst_n;
	logic vol_down;
	logic [13:0] stim;
	logic [3:0] hiz;
	logic fault_n, warn_n, fault_oe_n, warn_oe_n;
	logic fault_pin, warn_pin;
	int err_total, total_checks, c, b;
	// pull-ups hold the pins high while released
	assign fault_pin = fault_oe_n ? 1'b1 : 1'b0;
	assign warn_pin = warn_oe_n ? 1'b1 : 1'b0;
	fpr_top dut (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n),
		.output_config_in(stim[13:12]),
		.overload_protection_in(stim[11:8]),
		.boot_uv_in(stim[7:4]),
		.thermal_shutdown_error_in(stim[3]),
		.thermal_warn_in(stim[2]),
		.clip_in(stim[1]),
		.undervoltage_protection_in(stim[0]),
		.hb_hiz_out(hiz),
		.fault_n_out(fault_n),
		.clip_thermal_warn_n_out(warn_n),
		.fault_oe_n_out(fault_oe_n),
		.warn_oe_n_out(warn_oe_n)
	);
	fpr_ctl_model ctl (
		.clk_sys_in(clk_sys_in),
		.rst_req_in(rst_req),
		.fault_pin_in(fault_pin),
		.warn_pin_in(warn_pin),
		.rst_n_out(rst_n),
		.vol_down_out(vol_down)
	);
	task print_verdict();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// pins must agree with the indicator outputs
	task chk(input logic [3:0] eh, input logic ef, input logic ew);
		logic [7:0] got, exp;
		got = {hiz, fault_n, warn_n, fault_pin, warn_pin};
		exp = {eh, ef, ew, ef, ew};
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// the controller model's volume cut follows the warning pin
	task chk_vol(input logic ev);
		total_checks++;
		if (vol_down !== ev) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, vol_down, ev);
		end
	endtask
	// seven falling edges cover the five-edge input latency
	task go(input logic [13:0] s);
		@(negedge clk_sys_in);
		stim = s;
		repeat (7) @(negedge clk_sys_in);
	endtask
	task rst_cycle();
		@(negedge clk_sys_in);
		rst_req = 1'b1;
		repeat (2) @(negedge clk_sys_in);
		chk(4'hf, 1'b1, 1'b1);
		rst_req = 1'b0;
		repeat (7) @(negedge clk_sys_in);
	endtask
	function automatic logic [3:0] scope(input int cf, input int bit_i);
		if (cf == 2)
			return `FPR_HB_ALL;
		return (bit_i < 2) ? `FPR_HB_AB : `FPR_HB_CD;
	endfunction
	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	initial begin
		repeat (4000) @(posedge clk_sys_in);
		err_total++;
		print_verdict();
	end
	initial begin
		err_total = 0;
		total_checks = 0;
		rst_req = 1'b1;
		stim = 14'h0;
		repeat (6) @(negedge clk_sys_in);
		rst_req = 1'b0;
		repeat (7) @(negedge clk_sys_in);
		chk(4'h0, 1'b1, 1'b1);
		go(14'h0004); chk(4'h0, 1'b1, 1'b0);
		chk_vol(1'b1);
		go(14'h0002); chk(4'h0, 1'b1, 1'b0);
		go(14'h0000); chk(4'h0, 1'b1, 1'b1);
		chk_vol(1'b0);
		for (c = 0; c < 4; c++) begin
			@(negedge clk_sys_in);
			stim = {c[1:0], 12'h001};
			repeat (2) @(negedge clk_sys_in);
			chk(4'h0, 1'b1, 1'b1);
			repeat (5) @(negedge clk_sys_in);
			chk(4'hf, 1'b0, 1'b1);
			go({c[1:0], 12'h005}); chk(4'hf, 1'b0, 1'b0);
			go({c[1:0], 12'h000}); chk(4'h0, 1'b1, 1'b1);
			for (b = 0; b < 4; b++) begin
				go({c[1:0], 4'h0, 4'h1 << b, 4'h0});
				chk(4'h1 << b, 1'b1, 1'b1);
				go({c[1:0], 12'h000}); chk(4'h0, 1'b1, 1'b1);
				go({c[1:0], 4'h1 << b, 8'h00});
				chk(scope(c, b), 1'b0, 1'b1);
				go({c[1:0], 12'h000}); chk(scope(c, b), 1'b0, 1'b1);
				rst_cycle();
				chk(4'h0, 1'b1, 1'b1);
			end
		end
		go(14'h0008); chk(4'hf, 1'b0, 1'b1);
		go(14'h000c); chk(4'hf, 1'b0, 1'b0);
		go(14'h0000); chk(4'hf, 1'b0, 1'b1);
		rst_cycle();
		chk(4'h0, 1'b1, 1'b1);
		go(14'h0001); chk(4'hf, 1'b0, 1'b1);
		rst_cycle();
		chk(4'hf, 1'b0, 1'b1);
		go(14'h0000); chk(4'h0, 1'b1, 1'b1);
		print_verdict();
	end
endmodule
`default_nettype wire
